// *** fl_erase_suspend_ctl.sv ***
/*
 Command block for full erase, suspend/resume, sleep/wake and identity reads.
 Assumes neighbouring command blocks drive extBusy/extIsErase for their own
 self-timed cycles, freeze while pausedOperationFlag is high, honour cmdGrant
 and own the write enable latch, clearing it on writeEnableLatchClear.
*/
`timescale 1ns/1ns
`include "fl_consts.svh"

module fl_erase_suspend_ctl #(
   parameter logic [7:0]  MANUF_ID      = `FL_MANUF_ID,  // value arbitrary
   parameter logic [7:0]  DEVICE_ID     = `FL_DEVICE_ID, // value arbitrary
   parameter int unsigned FULL_ERASE_MS = `FL_FULL_ERASE_TIME_MS,
   parameter int unsigned PAUSE_US      = `FL_PAUSE_LATENCY_US,
   parameter int unsigned SLEEP_US      = `FL_SLEEP_ENTRY_TIME_US,
   parameter int unsigned WAKE_US       = `FL_WAKE_TIME_US,
   parameter int unsigned WAKE_ID_US    = `FL_WAKE_WITH_ID_TIME_US,
   parameter int unsigned ERASE_CYC     = FULL_ERASE_MS * `FL_NS_PER_MS / `FL_CLK_PERIOD_NS,
   parameter int unsigned PAUSE_CYC     = PAUSE_US * `FL_NS_PER_US / `FL_CLK_PERIOD_NS,
   parameter int unsigned SLEEP_CYC     = SLEEP_US * `FL_NS_PER_US / `FL_CLK_PERIOD_NS,
   parameter int unsigned WAKE_CYC      = WAKE_US * `FL_NS_PER_US / `FL_CLK_PERIOD_NS,
   parameter int unsigned WAKE_ID_CYC   = WAKE_ID_US * `FL_NS_PER_US / `FL_CLK_PERIOD_NS
) (
   input  wire logic       clk,
   input  wire logic       srst,
   input  wire logic       csN,
   input  wire logic       sclk,
   input  wire logic [3:0] ioIn,
   output logic      [3:0] ioOut,
   output logic      [3:0] ioOeN,
   input  wire logic       quadMode,
   input  wire logic       writeEnableLatch,
   input  wire logic       protectComplement,
   input  wire logic       blockProtectBit2,
   input  wire logic       blockProtectBit1,
   input  wire logic       blockProtectBit0,
   input  wire logic       extBusy,
   input  wire logic       extIsErase,
   output logic            busy,
   output logic            pausedOperationFlag,
   output logic            pauseIsErase,
   output logic            suspendPulse,
   output logic            resumePulse,
   output logic            writeEnableLatchClear,
   output logic            fullEraseActive,
   output logic            fullEraseDone,
   output logic            asleep,
   output logic            cmdStrobe,
   output logic      [7:0] cmdByte,
   output logic            cmdGrant
);
   logic            frameStart, frameEnd, frameExact8, sclkFall, byteStb;
   logic      [7:0] byteVal;
   logic      [2:0] byteIdx;
   logic      [7:0] op_q, opNow;
   logic            opSeen_q, opStb, oneByteEnd;
   logic            ceBusy, ceDone, pauseDone, sleepDone, wakeDone;
   logic            sus_q, pauseIsErase_q, pauseElapsed_q;
   logic            busyNow, awake, idle, protectAny;
   logic            ceGo, susGo, resGo, sleepGo, wakeGo;
   fl_pkg::fl_pwr_t pwr_q;
   logic            busy_q, suspendPulse_q, resumePulse_q, welClear_q;
   logic            ceDone_q, ceActive_q, cmdStrobe_q, cmdGrant_q;
   logic      [7:0] cmdByte_q;
   logic            txOn_q, txSel_q, txStart, selNow, txWrap, idOk;
   logic      [7:0] txSh_q, txCur, selByte;
   logic      [2:0] txCnt_q, cntNow, txCntNext, step;
   logic      [3:0] ioOut_q, ioOeN_q;

   // ==========================================================
   // opcode decoding
   function automatic logic fnFullErase(input logic [7:0] op);
      return (op == `FL_OP_FULL_ERASE_A) || (op == `FL_OP_FULL_ERASE_B);
   endfunction : fnFullErase

   function automatic logic fnEraseOp(input logic [7:0] op);
      return fnFullErase(op) || (op == `FL_OP_SECTOR_ERASE) ||
             (op == `FL_OP_BLOCK32_ERASE) || (op == `FL_OP_BLOCK64_ERASE) ||
             (op == `FL_OP_SECREG_ERASE);
   endfunction : fnEraseOp

   function automatic logic fnProgOp(input logic [7:0] op);
      return (op == `FL_OP_PAGE_PROG) || (op == `FL_OP_QUAD_PROG) ||
             (op == `FL_OP_SECREG_PROG);
   endfunction : fnProgOp

   // opcodes refused while an erase or a program stands paused
   function automatic logic fnPauseForbid(input logic [7:0] op, input logic paused,
                                          input logic isErase);
      return paused && ((op == `FL_OP_STATUS_WRITE) ||
                        (isErase ? fnEraseOp(op) : fnProgOp(op)));
   endfunction : fnPauseForbid

   // ==========================================================
   // receiver and timers
   fl_frame_rx uRx (
      .clk        (clk),
      .srst       (srst),
      .csN        (csN),
      .sclk       (sclk),
      .ioIn       (ioIn),
      .quadMode   (quadMode),
      .frameStart (frameStart),
      .frameEnd   (frameEnd),
      .frameExact8(frameExact8),
      .sclkFall   (sclkFall),
      .byteStb    (byteStb),
      .byteVal    (byteVal),
      .byteIdx    (byteIdx)
   );

   fl_countdown uErase (.clk(clk), .srst(srst), .start(ceGo),
      .startVal(`FL_CNT_W'(ERASE_CYC)), .cancel(1'b0), .busy(ceBusy), .done(ceDone));

   fl_countdown uPause (.clk(clk), .srst(srst), .start(susGo),
      .startVal(`FL_CNT_W'(PAUSE_CYC)), .cancel(resGo), .busy(), .done(pauseDone));

   fl_countdown uSleep (.clk(clk), .srst(srst), .start(sleepGo),
      .startVal(`FL_CNT_W'(SLEEP_CYC)), .cancel(1'b0), .busy(), .done(sleepDone));

   // WAKE_ID_CYC replaces WAKE_CYC when dummies followed, i.e. identity was read
   fl_countdown uWake (.clk(clk), .srst(srst), .start(wakeGo),
      .startVal(frameExact8 ? `FL_CNT_W'(WAKE_CYC) : `FL_CNT_W'(WAKE_ID_CYC)),
      .cancel(1'b0), .busy(), .done(wakeDone));

   // ==========================================================
   // opcode capture
   assign opStb = byteStb && (byteIdx == 3'h0);
   // chip select may rise in the same cycle the opcode strobe appears
   assign opNow = opStb ? byteVal : op_q;
   // one-byte commands act only when exactly eight bits preceded chip select
   assign oneByteEnd = frameEnd && frameExact8;

   always_ff @(posedge clk) begin
      if (srst) begin
         op_q     <= '0;
         opSeen_q <= 1'b0;
      end else if (frameStart) begin
         opSeen_q <= 1'b0;
      end else if (opStb) begin
         op_q     <= byteVal;
         opSeen_q <= 1'b1;
      end
   end

   // ==========================================================
   // status and acceptance terms
   // a paused neighbour cycle reads idle only once the pause latency has run
   assign busyNow    = ceBusy || (extBusy && !pauseElapsed_q);
   assign awake      = (pwr_q == fl_pkg::PWR_AWAKE);
   assign idle       = awake && !busyNow;
   assign protectAny = protectComplement ?
      ({blockProtectBit2, blockProtectBit1, blockProtectBit0} != `FL_BP_ALL) :
      ({blockProtectBit2, blockProtectBit1, blockProtectBit0} != `FL_BP_NONE);

   assign ceGo    = oneByteEnd && fnFullErase(opNow) && idle && writeEnableLatch &&
                    !protectAny && !fnPauseForbid(opNow, sus_q, pauseIsErase_q);
   assign susGo   = oneByteEnd && (opNow == `FL_OP_SUSPEND) && awake && !sus_q &&
                    busyNow && extBusy && !ceBusy;
   assign resGo   = oneByteEnd && (opNow == `FL_OP_RESUME) && awake && sus_q &&
                    !busyNow;
   assign sleepGo = oneByteEnd && (opNow == `FL_OP_SLEEP) && idle;
   assign wakeGo  = frameEnd && (pwr_q == fl_pkg::PWR_ASLEEP) && (opSeen_q || opStb) &&
                    (opNow == `FL_OP_WAKE_ID);

   // ==========================================================
   // pause flag
   always_ff @(posedge clk) begin
      if (srst) begin
         sus_q          <= 1'b0;
         pauseIsErase_q <= 1'b0;
         pauseElapsed_q <= 1'b0;
      end else if (susGo) begin
         sus_q          <= 1'b1;
         pauseIsErase_q <= extIsErase;
         pauseElapsed_q <= 1'b0;
      end else if (resGo) begin
         sus_q          <= 1'b0;
         pauseElapsed_q <= 1'b0;
      end else if (pauseDone) begin
         pauseElapsed_q <= 1'b1;
      end
   end

   // ==========================================================
   // power mode
   always_ff @(posedge clk) begin
      if (srst) begin
         pwr_q <= fl_pkg::PWR_AWAKE;
      end else begin
         case (pwr_q)
            fl_pkg::PWR_AWAKE: begin
               if (sleepGo) begin
                  pwr_q <= fl_pkg::PWR_ENTER;
               end
            end
            fl_pkg::PWR_ENTER: begin
               if (sleepDone) begin
                  pwr_q <= fl_pkg::PWR_ASLEEP;
               end
            end
            fl_pkg::PWR_ASLEEP: begin
               if (wakeGo) begin
                  pwr_q <= fl_pkg::PWR_WAKE;
               end
            end
            fl_pkg::PWR_WAKE: begin
               // everything is ignored until the wake time has run
               if (wakeDone) begin
                  pwr_q <= fl_pkg::PWR_AWAKE;
               end
            end
            default: begin
               pwr_q <= fl_pkg::PWR_AWAKE;
            end
         endcase
      end
   end

   // ==========================================================
   // command report to neighbouring blocks
   always_ff @(posedge clk) begin
      if (srst) begin
         cmdStrobe_q <= 1'b0;
         cmdByte_q   <= '0;
         cmdGrant_q  <= 1'b0;
      end else begin
         cmdStrobe_q <= opStb;
         if (opStb) begin
            cmdByte_q  <= byteVal;
            cmdGrant_q <= awake && !fnPauseForbid(byteVal, sus_q, pauseIsErase_q) &&
                          (!busyNow || (byteVal == `FL_OP_STATUS_READ) ||
                           (byteVal == `FL_OP_SUSPEND));
         end
      end
   end

   // ==========================================================
   // status outputs and pulses
   always_ff @(posedge clk) begin
      if (srst) begin
         busy_q         <= 1'b0;
         suspendPulse_q <= 1'b0;
         resumePulse_q  <= 1'b0;
         welClear_q     <= 1'b0;
         ceDone_q       <= 1'b0;
         ceActive_q     <= 1'b0;
      end else begin
         busy_q         <= busyNow;
         suspendPulse_q <= susGo;
         resumePulse_q  <= resGo;
         welClear_q     <= ceDone;
         ceDone_q       <= ceDone;
         ceActive_q     <= ceBusy;
      end
   end

   // ==========================================================
   // identity shifter
   assign step   = quadMode ? `FL_STEP_QUAD : `FL_STEP_SINGLE;
   assign idOk   = ((op_q == `FL_OP_WAKE_ID) && (idle || pwr_q == fl_pkg::PWR_ASLEEP)) ||
                   ((op_q == `FL_OP_MFR_DEV_ID) && idle);
   assign txStart = byteStb && (byteIdx == `FL_ID_DATA_IDX) && idOk && !txOn_q;
   // address bit zero set swaps the order, starting with the device byte
   assign selNow  = txStart ? byteVal[0] : txSel_q;
   assign selByte = ((op_q == `FL_OP_MFR_DEV_ID) && !selNow) ? MANUF_ID : DEVICE_ID;
   assign cntNow  = txStart ? 3'h0 : txCnt_q;
   assign txCur   = (cntNow == 3'h0) ? selByte : txSh_q;
   assign txCntNext = cntNow + step;
   assign txWrap  = (txCntNext == 3'h0);

   always_ff @(posedge clk) begin
      if (srst || frameEnd) begin
         txOn_q  <= 1'b0;
         txSel_q <= 1'b0;
         txSh_q  <= '0;
         txCnt_q <= '0;
         ioOut_q <= '0;
         ioOeN_q <= `FL_OE_NONE;
      end else begin
         if (txStart) begin
            txOn_q  <= 1'b1;
            txCnt_q <= 3'h0;
            txSel_q <= byteVal[0];
         end
         if (sclkFall && (txOn_q || txStart)) begin
            // falling edges, msb first; the byte repeats or alternates
            ioOut_q <= quadMode ? txCur[7:4] : {2'b00, txCur[7], 1'b0};
            ioOeN_q <= quadMode ? `FL_OE_QUAD : `FL_OE_SINGLE;
            txSh_q  <= quadMode ? {txCur[3:0], 4'h0} : {txCur[6:0], 1'b0};
            txCnt_q <= txCntNext;
            txSel_q <= (txWrap && op_q == `FL_OP_MFR_DEV_ID) ? !selNow : selNow;
         end
      end
   end

   // ==========================================================
   // outputs
   assign ioOut                 = ioOut_q;
   assign ioOeN                 = ioOeN_q;
   assign busy                  = busy_q;
   assign pausedOperationFlag   = sus_q;
   assign pauseIsErase          = pauseIsErase_q;
   assign suspendPulse          = suspendPulse_q;
   assign resumePulse           = resumePulse_q;
   assign writeEnableLatchClear = welClear_q;
   assign fullEraseActive       = ceActive_q;
   assign fullEraseDone         = ceDone_q;
   assign asleep                = (pwr_q != fl_pkg::PWR_AWAKE);
   assign cmdStrobe             = cmdStrobe_q;
   assign cmdByte               = cmdByte_q;
   assign cmdGrant              = cmdGrant_q;
endmodule : fl_erase_suspend_ctl

// *** fl_consts.svh ***
/*
 Named constants for the erase / suspend / sleep / identity command block.
 Assumes it is included by bare name from every design file that needs it.
*/
`ifndef FL_CONSTS_SVH
`define FL_CONSTS_SVH

// ==========================================================
// opcodes
`define FL_OP_FULL_ERASE_A  8'hC7
`define FL_OP_FULL_ERASE_B  8'h60
`define FL_OP_SUSPEND       8'h75
`define FL_OP_RESUME        8'h7A
`define FL_OP_SLEEP         8'hB9
`define FL_OP_WAKE_ID       8'hAB
`define FL_OP_MFR_DEV_ID    8'h90
`define FL_OP_STATUS_WRITE  8'h01
`define FL_OP_STATUS_READ   8'h05
`define FL_OP_SECTOR_ERASE  8'h20
`define FL_OP_BLOCK32_ERASE 8'h52
`define FL_OP_BLOCK64_ERASE 8'hD8
`define FL_OP_SECREG_ERASE  8'h44
`define FL_OP_PAGE_PROG     8'h02
`define FL_OP_QUAD_PROG     8'h32
`define FL_OP_SECREG_PROG   8'h42

// ==========================================================
// framing
`define FL_OPCODE_BITS      6'h08
`define FL_BITCNT_MAX       6'h3F
`define FL_BYTEIDX_MAX      3'h7
`define FL_ID_DATA_IDX      3'h3
`define FL_STEP_SINGLE      3'h1
`define FL_STEP_QUAD        3'h4
`define FL_OE_NONE          4'hF
`define FL_OE_SINGLE        4'hD
`define FL_OE_QUAD          4'h0
`define FL_BP_NONE          3'h0
`define FL_BP_ALL           3'h7

// ==========================================================
// timing
`define FL_CNT_W                32
`define FL_CLK_PERIOD_NS        4
`define FL_NS_PER_US            1000
`define FL_NS_PER_MS            1000000
`define FL_FULL_ERASE_TIME_MS   10
`define FL_PAUSE_LATENCY_US     20
`define FL_SLEEP_ENTRY_TIME_US  3
`define FL_WAKE_TIME_US         3
`define FL_WAKE_WITH_ID_TIME_US 2

// ==========================================================
// identity (values arbitrary)
`define FL_MANUF_ID         8'h5A
`define FL_DEVICE_ID        8'h3C

`endif

// *** fl_pkg.sv ***
/*
 Types shared by the command block.
 Assumes nothing of its surroundings.
*/
package fl_pkg;
   // ==========================================================
   // power mode
   typedef enum logic [1:0] {PWR_AWAKE, PWR_ENTER, PWR_ASLEEP, PWR_WAKE} fl_pwr_t;
endpackage : fl_pkg

// *** fl_countdown.sv ***
/*
 Loadable countdown for self-timed intervals.
 Assumes start values of at least one.
*/
`timescale 1ns/1ns
`include "fl_consts.svh"

module fl_countdown (
   input  wire logic                 clk,
   input  wire logic                 srst,
   input  wire logic                 start,
   input  wire logic [`FL_CNT_W-1:0] startVal,
   input  wire logic                 cancel,
   output logic                      busy,
   output logic                      done
);
   logic [`FL_CNT_W-1:0] cnt_q;
   logic                 done_q;

   // ==========================================================
   // counter
   always_ff @(posedge clk) begin
      if (srst || cancel) begin
         cnt_q <= '0;
      end else if (start) begin
         cnt_q <= startVal;
      end else if (cnt_q != '0) begin
         cnt_q <= cnt_q - 1'b1;
      end
   end

   always_ff @(posedge clk) begin
      if (srst) begin
         done_q <= 1'b0;
      end else begin
         done_q <= (cnt_q == `FL_CNT_W'(1)) && !start && !cancel;
      end
   end

   assign busy = (cnt_q != '0);
   assign done = done_q;
endmodule : fl_countdown

// *** fl_frame_rx.sv ***
/*
 Serial frame receiver: edges of chip select and serial clock, byte assembly.
 Assumes pins synchronous to clk and serial clock at most a quarter of clk.
*/
`timescale 1ns/1ns
`include "fl_consts.svh"

module fl_frame_rx (
   input  wire logic       clk,
   input  wire logic       srst,
   input  wire logic       csN,
   input  wire logic       sclk,
   input  wire logic [3:0] ioIn,
   input  wire logic       quadMode,
   output logic            frameStart,
   output logic            frameEnd,
   output logic            frameExact8,
   output logic            sclkFall,
   output logic            byteStb,
   output logic [7:0]      byteVal,
   output logic [2:0]      byteIdx
);
   logic       csPrev_q, sclkPrev_q, sclkRise, byteStb_q;
   logic [7:0] sh_q, sh_d, byteVal_q;
   logic [5:0] bitCnt_q;
   logic [2:0] byteCnt_q, byteIdx_q, step, posNext;

   assign sclkRise    = !csN && sclk && !sclkPrev_q;
   assign sclkFall    = !csN && !sclk && sclkPrev_q;
   assign frameStart  = csPrev_q && !csN;
   assign frameEnd    = !csPrev_q && csN;
   assign frameExact8 = (bitCnt_q == `FL_OPCODE_BITS);
   assign step        = quadMode ? `FL_STEP_QUAD : `FL_STEP_SINGLE;
   assign posNext     = bitCnt_q[2:0] + step;
   // msb first, one or four bits per rising edge
   assign sh_d        = quadMode ? {sh_q[3:0], ioIn} : {sh_q[6:0], ioIn[0]};

   // ==========================================================
   // pin edges
   always_ff @(posedge clk) begin
      if (srst) begin
         csPrev_q   <= 1'b1;
         sclkPrev_q <= 1'b0;
      end else begin
         csPrev_q   <= csN;
         sclkPrev_q <= sclk;
      end
   end

   // ==========================================================
   // bit and byte assembly
   always_ff @(posedge clk) begin
      if (srst || frameStart) begin
         sh_q     <= '0;
         bitCnt_q <= '0;
      end else if (sclkRise) begin
         sh_q     <= sh_d;
         bitCnt_q <= (bitCnt_q > `FL_BITCNT_MAX - step) ? `FL_BITCNT_MAX
                                                        : bitCnt_q + {3'h0, step};
      end
   end

   always_ff @(posedge clk) begin
      if (srst) begin
         byteStb_q <= 1'b0;
         byteVal_q <= '0;
         byteIdx_q <= '0;
         byteCnt_q <= '0;
      end else begin
         byteStb_q <= 1'b0;
         if (frameStart) begin
            byteCnt_q <= '0;
         end else if (sclkRise && posNext == 3'h0) begin
            byteStb_q <= 1'b1;
            byteVal_q <= sh_d;
            byteIdx_q <= byteCnt_q;
            if (byteCnt_q != `FL_BYTEIDX_MAX) begin
               byteCnt_q <= byteCnt_q + 1'b1;
            end
         end
      end
   end

   assign byteStb = byteStb_q;
   assign byteVal = byteVal_q;
   assign byteIdx = byteIdx_q;
endmodule : fl_frame_rx

// *** fl_ctl_monitor.sv ***
/* Assertion checker on the command block ports.
 Assumes one clock domain and a bind by name. */
`timescale 1ns/1ns
module fl_ctl_monitor #(
   parameter int unsigned PAUSE_CYC = 8
) (
   input wire logic       clk, srst, csN, writeEnableLatch, extBusy, protectComplement,
   input wire logic       blockProtectBit2, blockProtectBit1, blockProtectBit0, busy,
   input wire logic       pausedOperationFlag, pauseIsErase, suspendPulse, resumePulse,
   input wire logic       writeEnableLatchClear, fullEraseActive, fullEraseDone, asleep,
   input wire logic       cmdStrobe, cmdGrant,
   input wire logic [3:0] ioOeN,
   input wire logic [7:0] cmdByte
);
   // slack covers the registered busy output
   localparam int PL = PAUSE_CYC + 4;
   default clocking @(posedge clk); endclocking
   default disable iff (srst);
   sequence sNoneProtected;
      protectComplement ? ({blockProtectBit2, blockProtectBit1, blockProtectBit0} == 3'h7)
                        : ({blockProtectBit2, blockProtectBit1, blockProtectBit0} == 3'h0);
   endsequence
   sequence sPauseStart;
      $rose(pausedOperationFlag);
   endsequence
   AST_AWAKE_AFTER_RST: assert property ($fell(srst) |->
      !asleep && !pausedOperationFlag)
      else $error("asleep or paused after reset");
   AST_ERASE_NEEDS_WEL: assert property ($rose(fullEraseActive) |-> writeEnableLatch)
      else $error("full erase started without latch");
   AST_ERASE_UNPROT: assert property ($rose(fullEraseActive) |-> sNoneProtected)
      else $error("full erase started while protected");
   AST_ERASE_BUSY: assert property (fullEraseActive ##1 fullEraseActive |-> busy)
      else $error("busy low during full erase");
   AST_DONE_CLEARS_WEL: assert property (fullEraseDone |->
      writeEnableLatchClear && $past(busy) && !fullEraseActive)
      else $error("no latch clear at erase end");
   AST_SUSPEND_COND: assert property (suspendPulse |->
      !$past(pausedOperationFlag) && extBusy && !fullEraseActive && pausedOperationFlag)
      else $error("suspend taken in wrong state");
   AST_SUSPEND_LAT: assert property (sPauseStart |-> ##[1:PL] !busy)
      else $error("busy not cleared after suspend");
   AST_RESUME: assert property (resumePulse |->
      $past(pausedOperationFlag) && !$past(busy) && !pausedOperationFlag ##[0:50] busy)
      else $error("resume taken wrongly or busy late");
   AST_SLEEP_DEAF: assert property (
      cmdStrobe && asleep && cmdByte != 8'hAB |-> !cmdGrant)
      else $error("command granted while asleep");
   AST_BUSY_DEAF: assert property (
      cmdStrobe && busy && !(cmdByte inside {8'h05, 8'h75}) |-> !cmdGrant)
      else $error("command granted while busy");
   AST_ERASE_LOCK: assert property (cmdStrobe && pausedOperationFlag && pauseIsErase &&
      (cmdByte inside {8'h01, 8'h20, 8'h52, 8'hD8, 8'hC7, 8'h60, 8'h44}) |-> !cmdGrant)
      else $error("locked opcode granted in erase pause");
   AST_PROG_LOCK: assert property (cmdStrobe && pausedOperationFlag && !pauseIsErase &&
      (cmdByte inside {8'h01, 8'h02, 8'h32, 8'h42}) |-> !cmdGrant)
      else $error("locked opcode granted in program pause");
   AST_LINE_IDLE: assert property (csN [*3] |-> ioOeN == 4'hF)
      else $error("data line driven outside frame");
endmodule : fl_ctl_monitor
bind fl_erase_suspend_ctl fl_ctl_monitor #(.PAUSE_CYC(PAUSE_CYC)) MON (.*);

// *** fl_host_model.sv ***
/* Single-line or quad host controller model for the command block.
 Assumes sclk at a quarter of clk, mode 0, idle low. */
`timescale 1ns/1ns
module fl_host_model (
   input  wire logic       clk,
   output logic            csN,
   output logic            sclk,
   output logic      [3:0] ioIn,
   input  wire logic [3:0] ioOut,
   input  wire logic [3:0] ioOeN,
   input  wire logic       quadMode
);
   logic [15:0] rdData;
   logic        oeSeen;
   initial begin
      csN = 1'b1;
      sclk = 1'b0;
      ioIn = 4'h0;
   end
   // sends tx msb first for nb clocks of one or four bits each, then clocks nr more back
   task automatic xfer(input logic [31:0] tx, input int nb, input int nr);
      oeSeen = 1'b0;
      @(posedge clk) csN <= 1'b0;
      for (int i = 0; i < nb + nr; i++) begin
         @(posedge clk) sclk <= 1'b0;
         ioIn <= (i >= nb) ? ~ioIn : quadMode ? tx[31 - 4 * i -: 4]
                                              : {3'h0, tx[31 - i]};
         @(posedge clk);
         @(posedge clk) sclk <= 1'b1;
         @(posedge clk) oeSeen = oeSeen | (ioOeN[1] === 1'b0);
         // undriven lines read as pulled up
         if (i >= nb) rdData = quadMode ? {rdData[11:0], ioOut | ioOeN}
                                        : {rdData[14:0], ioOut[1] | ioOeN[1]};
      end
      @(posedge clk) csN <= 1'b1;
      sclk <= 1'b0;
      // released line toggles so a stale bit never looks valid
      ioIn <= ~ioIn;
      repeat (3) @(posedge clk);
   endtask : xfer
endmodule : fl_host_model

// *** testbench.sv ***
/* Self-checking bench for the command block.
 Assumes the host model drives the link; bench plays the neighbour. */
`timescale 1ns/1ns
`include "fl_consts.svh"
module testbench;
   logic       clk, srst, csN, sclk, quadMode, writeEnableLatch, protectComplement;
   logic       blockProtectBit2, blockProtectBit1, blockProtectBit0, extBusy, extIsErase;
   logic       busy, pausedOperationFlag, pauseIsErase, suspendPulse, resumePulse, asleep;
   logic       writeEnableLatchClear, fullEraseActive, fullEraseDone, cmdStrobe, cmdGrant;
   logic [3:0] ioIn, ioOut, ioOeN;
   logic [7:0] cmdByte;
   logic [8:0] expQ[$];
   int         errorCnt, numChecks, cyc;
   fl_erase_suspend_ctl #(.ERASE_CYC(400), .PAUSE_CYC(8), .SLEEP_CYC(8), .WAKE_CYC(8),
      .WAKE_ID_CYC(10)) DUT (.*);
   fl_host_model HOST (.*);
   initial begin
      clk = 1'b0;
      forever #2 clk = ~clk;
   end
   task automatic stopTest();
      if (errorCnt == 0 && numChecks > 0) $display("TB: PASS");
      else $display("TB: FAIL");
      $finish;
   endtask : stopTest
   task automatic chk(input string nm, input logic [15:0] exp, input logic [15:0] got);
      numChecks++;
      if (got !== exp) begin
         errorCnt++;
         $display("mismatch %s expected %h seen %h", nm, exp, got);
      end
   endtask : chk
   task automatic cmd(input logic [7:0] op, input logic gr);
      expQ.push_back({gr, op});
      HOST.xfer({op, 24'h0}, 8, 0);
   endtask : cmd
   task automatic waitBusy(input logic lvl);
      int n;
      n = 0;
      while (busy !== lvl && n < 600) begin
         @(posedge clk);
         n++;
      end
      chk("busy", lvl, busy);
   endtask : waitBusy
   always @(posedge clk) begin
      if (cmdStrobe === 1'b1 && expQ.size() > 0) chk("cmd", expQ.pop_front(), {cmdGrant, cmdByte});
      if (writeEnableLatchClear === 1'b1) writeEnableLatch <= 1'b0;
      cyc <= cyc + 1;
      if (cyc == 20000) begin
         errorCnt++;
         stopTest();
      end
   end
   initial begin
      void'($urandom(62));
      {srst, quadMode, writeEnableLatch, protectComplement, extBusy, extIsErase} = 6'h20;
      {blockProtectBit2, blockProtectBit1, blockProtectBit0} = 3'h0;
      repeat (5) @(posedge clk);
      srst <= 1'b0;
      @(posedge clk);
      chk("asleep", 0, asleep);
      cmd(8'hC7, 1'b1);
      chk("busy", 0, busy);
      writeEnableLatch <= 1'b1;
      blockProtectBit0 <= 1'b1;
      cmd(8'h60, 1'b1);
      chk("busy", 0, busy);
      blockProtectBit0 <= 1'b0;
      HOST.xfer({8'hC7, 24'h0}, 9, 0);
      chk("busy", 0, busy);
      {protectComplement, blockProtectBit2, blockProtectBit1, blockProtectBit0} <= 4'hF;
      HOST.xfer({8'h60, 24'h0}, 8, 0);
      waitBusy(1);
      cmd(8'h05, 1'b1);
      cmd(8'h75, 1'b1);
      chk("paused", 0, pausedOperationFlag);
      expQ.push_back({1'b0, 8'hAB});
      HOST.xfer({8'hAB, 24'h0}, 32, 8);
      chk("idDrive", 0, HOST.oeSeen);
      waitBusy(0);
      repeat (3) @(posedge clk);
      chk("latch", 0, writeEnableLatch);
      {protectComplement, blockProtectBit2, blockProtectBit1, blockProtectBit0} <= 4'h0;
      extBusy <= 1'b1;
      extIsErase <= 1'b1;
      waitBusy(1);
      HOST.xfer({8'h75, 24'h0}, 8, 0);
      chk("paused", 1, pausedOperationFlag);
      chk("pauseIsErase", 1, pauseIsErase);
      waitBusy(0);
      writeEnableLatch <= 1'b1;
      cmd(8'h01, 1'b0);
      cmd(8'h20, 1'b0);
      cmd(8'hC7, 1'b0);
      HOST.xfer({8'h7A, 24'h0}, 8, 0);
      chk("paused", 0, pausedOperationFlag);
      waitBusy(1);
      repeat (12) @(posedge clk);
      extIsErase <= 1'b0;
      HOST.xfer({8'h75, 24'h0}, 8, 0);
      waitBusy(0);
      chk("pauseIsErase", 0, pauseIsErase);
      cmd(8'h32, 1'b0);
      srst <= 1'b1;
      repeat (2) @(posedge clk);
      srst <= 1'b0;
      HOST.xfer({8'h7A, 24'h0}, 8, 0);
      chk("paused", 0, pausedOperationFlag);
      extBusy <= 1'b0;
      writeEnableLatch <= 1'b0;
      HOST.xfer({8'h75, 24'h0}, 8, 0);
      chk("paused", 0, pausedOperationFlag);
      HOST.xfer({8'hAB, 24'($urandom)}, 32, 8);
      chk("devId", `FL_DEVICE_ID, HOST.rdData[7:0]);
      HOST.xfer({8'h90, 24'h0}, 32, 16);
      chk("bothIds", {`FL_MANUF_ID, `FL_DEVICE_ID}, HOST.rdData);
      quadMode <= 1'b1;
      HOST.xfer({8'h90, 24'h1}, 8, 4);
      chk("quadIds", {`FL_DEVICE_ID, `FL_MANUF_ID}, HOST.rdData);
      quadMode <= 1'b0;
      HOST.xfer({8'hB9, 24'h0}, 9, 0);
      chk("asleep", 0, asleep);
      HOST.xfer({8'hB9, 24'h0}, 8, 0);
      repeat (12) @(posedge clk);
      chk("asleep", 1, asleep);
      expQ.push_back({1'b0, 8'h90});
      HOST.xfer({8'h90, 24'h0}, 32, 16);
      chk("idDrive", 0, HOST.oeSeen);
      HOST.xfer({8'hAB, 24'h0}, 8, 0);
      chk("asleep", 1, asleep);
      repeat (12) @(posedge clk);
      chk("asleep", 0, asleep);
      HOST.xfer({8'hB9, 24'h0}, 8, 0);
      repeat (12) @(posedge clk);
      HOST.xfer({8'hAB, 24'h0}, 32, 8);
      chk("wakeId", `FL_DEVICE_ID, HOST.rdData[7:0]);
      chk("asleep", 1, asleep);
      repeat (12) @(posedge clk);
      chk("asleep", 0, asleep);
      stopTest();
   end
endmodule : testbench
